/* design/sfcg_top.sv */
`timescale 1ns/1ps
`include "sfcg_regs.svh"

module sfcg_top
    import sfcg_pkg::*;
#(
    parameter int PU_CYCLES = `SFCG_PU_CYCLES
) (
    // System clock and reset
    input  wire logic       CLK_SYS_IN,
    input  wire logic       RST_IN,
    // Serial link pins
    input  wire logic       CS_N_IN,
    input  wire logic       SCK_IN,
    input  wire logic       SI_IN,
    input  wire logic       HW_RESET_N_IN,
    // Supply monitor levels
    input  wire logic       VCC_ABOVE_MIN_IN,
    input  wire logic       VCC_ABOVE_CUTOFF_IN,
    // Command admission
    output logic            READY_OUT,
    output logic            CMD_ACCEPT_OUT,
    output logic [7:0]      CMD_OPCODE_OUT,
    output logic            EXEC_OUT,
    output logic            WLATCH_OUT,
    // Interface configuration
    output logic [7:0]      CFG_OUT,
    output logic [7:0]      MODE_CYCLES_OUT,
    output logic [7:0]      DUMMY_CYCLES_OUT,
    output logic            LATENCY_OUT,
    output logic [3:0]      IO_OE_OUT,
    output logic            HOLD_WP_EN_OUT
);

    localparam int PCW = $clog2(PU_CYCLES + 1);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [5:0] pins_s;
    logic       cs_n_s;
    logic       sck_s;
    logic       si_s;
    logic       hrst_n_s;
    logic       vmin_s;
    logic       vcut_s;

    sfcg_sync #(
        .WIDTH   (6),
        .RST_VAL (6'h24)
    ) u_sync (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (RST_IN),
        .async_in ({CS_N_IN, SCK_IN, SI_IN, HW_RESET_N_IN,
                    VCC_ABOVE_MIN_IN, VCC_ABOVE_CUTOFF_IN}),
        .sync_out (pins_s)
    );

    assign {cs_n_s, sck_s, si_s, hrst_n_s, vmin_s, vcut_s} = pins_s;

    // ------------------------------------------------------------
    // Instruction classes
    // ------------------------------------------------------------
    function automatic logic is_quad(input logic [7:0] op);
        is_quad = (op == `SFCG_OP_QUAD_PROG) || (op == `SFCG_OP_QUAD_OUT) ||
                  (op == `SFCG_OP_QIOR) || (op == `SFCG_OP_DDR_QIOR);
    endfunction : is_quad

    function automatic logic is_modify(input logic [7:0] op);
        is_modify = (op == `SFCG_OP_PP) || (op == `SFCG_OP_QUAD_PROG) ||
                    (op == `SFCG_OP_SE) || (op == `SFCG_OP_P4E) ||
                    (op == `SFCG_OP_BE) || (op == `SFCG_OP_WREG);
    endfunction : is_modify

    function automatic logic is_read(input logic [7:0] op);
        is_read = (op == `SFCG_OP_READ) || (op == `SFCG_OP_FAST_READ) ||
                  (op == `SFCG_OP_QUAD_OUT) || (op == `SFCG_OP_QIOR) ||
                  (op == `SFCG_OP_DDR_QIOR);
    endfunction : is_read

    // Edge count at which the address phase ends
    function automatic logic [15:0] addr_end(input logic [7:0] op);
        unique case (op)
            `SFCG_OP_QIOR:     addr_end = `SFCG_OPC_BITS + `SFCG_ADDR_QUAD;
            `SFCG_OP_DDR_QIOR: addr_end = `SFCG_OPC_BITS + `SFCG_ADDR_DDR;
            default:           addr_end = `SFCG_OPC_BITS + `SFCG_ADDR_SINGLE;
        endcase
    endfunction : addr_end

    function automatic logic [7:0] mode_of(input logic [7:0] op);
        unique case (op)
            `SFCG_OP_QIOR:     mode_of = `SFCG_MODE_QIO;
            `SFCG_OP_DDR_QIOR: mode_of = `SFCG_MODE_DDR;
            default:           mode_of = `SFCG_MODE_NONE;
        endcase
    endfunction : mode_of

    // Plain read has no latency whatever the code says
    function automatic logic [7:0] dummy_of(input logic [7:0] op,
                                            input logic [1:0] lc);
        logic [7:0] sdr;
        logic [7:0] ddr;
        sdr = (lc == 2'h0) ? `SFCG_DUMMY_LC0 :
              (lc == 2'h1) ? `SFCG_DUMMY_LC1 :
              (lc == 2'h2) ? `SFCG_DUMMY_LC2 : `SFCG_DUMMY_LC3;
        ddr = (lc == 2'h0) ? `SFCG_DDR_DUMMY_LC0 :
              (lc == 2'h1) ? `SFCG_DDR_DUMMY_LC1 :
              (lc == 2'h2) ? `SFCG_DDR_DUMMY_LC2 : `SFCG_DDR_DUMMY_LC3;
        if (op == `SFCG_OP_READ) begin
            dummy_of = 8'h00;
        end else if (op == `SFCG_OP_DDR_QIOR) begin
            dummy_of = ddr;
        end else begin
            dummy_of = sdr;
        end
    endfunction : dummy_of

    // ------------------------------------------------------------
    // Power sequencing
    // ------------------------------------------------------------
    sfcg_pwr_t      pwr_q;
    sfcg_pwr_t      pwr_d;
    logic [PCW-1:0] por_cnt_q;
    logic [PCW-1:0] por_cnt_d;
    logic           sw_reset_hit;
    logic           cmd_ready;

    // A drop below cut-off needs a full re-initialisation
    always_comb begin
        pwr_d     = pwr_q;
        por_cnt_d = por_cnt_q;
        if (!vcut_s) begin
            pwr_d     = PWR_OFF;
            por_cnt_d = '0;
        end else begin
            unique case (pwr_q)
                PWR_OFF: begin
                    if (vmin_s) begin
                        pwr_d = PWR_POR;
                    end
                end
                PWR_POR: begin
                    if (!vmin_s) begin
                        pwr_d = PWR_FAIL;
                    end else if (por_cnt_q == PCW'(PU_CYCLES - 1)) begin
                        pwr_d = PWR_READY;
                    end else begin
                        por_cnt_d = por_cnt_q + PCW'(1);
                    end
                end
                PWR_FAIL: begin
                    if (vmin_s && (!hrst_n_s || sw_reset_hit)) begin
                        pwr_d     = PWR_POR;
                        por_cnt_d = '0;
                    end
                end
                PWR_READY: begin
                    pwr_d = PWR_READY;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pwr_q     <= PWR_OFF;
            por_cnt_q <= '0;
        end else begin
            pwr_q     <= pwr_d;
            por_cnt_q <= por_cnt_d;
        end
    end

    assign cmd_ready = (pwr_q == PWR_READY) && vcut_s;

    // ------------------------------------------------------------
    // Frame tracking and command admission
    // ------------------------------------------------------------
    logic        cs_d_q;
    logic        sck_d_q;
    logic        cs_fall;
    logic        cs_rise;
    logic        sck_rise;
    logic [15:0] bits_q;
    logic [15:0] bits_d;
    logic [7:0]  op_q;
    logic [7:0]  op_d;
    logic [15:0] data_q;
    logic [15:0] data_d;
    logic        frame_ok_q;
    logic        frame_ok_d;
    logic        accept_q;
    logic        accept_d;
    logic        exec_q;
    logic        exec_d;
    logic        wlatch_q;
    logic        wlatch_d;
    logic [7:0]  cfg_q;
    logic [7:0]  cfg_d;
    logic [7:0]  mode_q;
    logic [7:0]  mode_d;
    logic [7:0]  dummy_q;
    logic [7:0]  dummy_d;
    logic [15:0] lat_start_q;
    logic [15:0] lat_start_d;
    logic        lat_q;
    logic        lat_d;
    logic [3:0]  oe_q;
    logic [3:0]  oe_d;
    logic [7:0]  op_full;
    logic        opc_done;
    logic        len_ok;

    assign cs_fall  = cs_d_q && !cs_n_s;
    assign cs_rise  = !cs_d_q && cs_n_s;
    assign sck_rise = sck_s && !sck_d_q && !cs_n_s;
    assign op_full  = {op_q[6:0], si_s};
    assign opc_done = sck_rise && (bits_q == `SFCG_OPC_BITS - 16'h0001);
    assign len_ok   = (bits_q[2:0] == 3'h0);
    assign sw_reset_hit = opc_done && (op_full == `SFCG_OP_SW_RESET);

    // Frame bookkeeping and the actions taken at its end
    always_comb begin
        bits_d      = bits_q;
        op_d        = op_q;
        data_d      = data_q;
        frame_ok_d  = frame_ok_q && cmd_ready && hrst_n_s;
        accept_d    = 1'b0;
        exec_d      = 1'b0;
        wlatch_d    = wlatch_q;
        cfg_d       = cfg_q;
        mode_d      = mode_q;
        dummy_d     = dummy_q;
        lat_start_d = lat_start_q;
        lat_d       = lat_q;
        oe_d        = oe_q;
        if (pwr_q != PWR_READY || !hrst_n_s) begin
            wlatch_d = 1'b0;
        end
        if (cs_fall) begin
            bits_d     = 16'h0000;
            op_d       = 8'h00;
            frame_ok_d = cmd_ready && hrst_n_s;
            lat_d      = 1'b0;
            oe_d       = 4'h0;
        end else if (sck_rise) begin
            if (bits_q != 16'hffff) begin
                bits_d = bits_q + 16'h0001;
            end
            if (bits_q < `SFCG_OPC_BITS) begin
                op_d = op_full;
            end else if (bits_q < `SFCG_WREG_FULL_BITS) begin
                data_d = {data_q[14:0], si_s};
            end
            if (opc_done && frame_ok_d) begin
                if (is_quad(op_full) && !cfg_q[`SFCG_CFG_QE_BIT]) begin
                    frame_ok_d = 1'b0;
                end else begin
                    accept_d    = 1'b1;
                    mode_d      = mode_of(op_full);
                    dummy_d     = dummy_of(op_full,
                                  cfg_q[`SFCG_CFG_LC_HI:`SFCG_CFG_LC_LO]);
                    lat_start_d = addr_end(op_full) + 16'(mode_of(op_full));
                end
            end
            // Latency window, then the memory may take the bus
            if (frame_ok_d && is_read(op_q) && !opc_done) begin
                lat_d = (bits_d >= lat_start_q) &&
                        (bits_d < lat_start_q + 16'(dummy_q));
                if (bits_d >= lat_start_q + 16'(dummy_q)) begin
                    oe_d = (op_q == `SFCG_OP_READ ||
                            op_q == `SFCG_OP_FAST_READ) ? 4'h2 : 4'hf;
                end else begin
                    oe_d = 4'h0;
                end
            end
        end else if (cs_rise) begin
            lat_d = 1'b0;
            oe_d  = 4'h0;
            // Odd lengths fall through with no flag at all; a supply
            // loss in this very cycle still cancels the command
            if (frame_ok_d && bits_q >= `SFCG_OPC_BITS) begin
                if (is_modify(op_q) && wlatch_q && len_ok) begin
                    exec_d   = 1'b1;
                    wlatch_d = 1'b0;
                    if (op_q == `SFCG_OP_WREG &&
                        bits_q == `SFCG_WREG_FULL_BITS) begin
                        cfg_d = data_q[7:0];
                    end
                end else if (op_q == `SFCG_OP_WREN &&
                             bits_q == `SFCG_OPC_BITS) begin
                    wlatch_d = 1'b1;
                end
            end
        end
    end

    // Configuration survives a pin reset; only system reset reloads 8'h02
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cs_d_q      <= 1'b1;
            sck_d_q     <= 1'b0;
            bits_q      <= 16'h0000;
            op_q        <= 8'h00;
            data_q      <= 16'h0000;
            frame_ok_q  <= 1'b0;
            accept_q    <= 1'b0;
            exec_q      <= 1'b0;
            wlatch_q    <= 1'b0;
            cfg_q       <= `SFCG_CFG_RESET;
            mode_q      <= 8'h00;
            dummy_q     <= 8'h00;
            lat_start_q <= 16'h0000;
            lat_q       <= 1'b0;
            oe_q        <= 4'h0;
        end else begin
            cs_d_q      <= cs_n_s;
            sck_d_q     <= sck_s;
            bits_q      <= bits_d;
            op_q        <= op_d;
            data_q      <= data_d;
            frame_ok_q  <= frame_ok_d;
            accept_q    <= accept_d;
            exec_q      <= exec_d;
            wlatch_q    <= wlatch_d;
            cfg_q       <= cfg_d;
            mode_q      <= mode_d;
            dummy_q     <= dummy_d;
            lat_start_q <= lat_start_d;
            lat_q       <= lat_d;
            oe_q        <= oe_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign READY_OUT        = (pwr_q == PWR_READY);
    assign CMD_ACCEPT_OUT   = accept_q;
    assign CMD_OPCODE_OUT   = op_q;
    assign EXEC_OUT         = exec_q;
    assign WLATCH_OUT       = wlatch_q;
    assign CFG_OUT          = cfg_q;
    assign MODE_CYCLES_OUT  = mode_q;
    assign DUMMY_CYCLES_OUT = dummy_q;
    assign LATENCY_OUT      = lat_q;
    assign IO_OE_OUT        = oe_q;
    // Hold and protect pins carry data in quad mode
    assign HOLD_WP_EN_OUT   = !cfg_q[`SFCG_CFG_QE_BIT];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);

    sequence s_odd_end;
        cs_rise && !len_ok;
    endsequence

    sequence s_por_done;
        (pwr_q == PWR_POR) && (por_cnt_q == PCW'(PU_CYCLES - 1)) && vmin_s
            && vcut_s;
    endsequence

    a_quad_gate: assert property (
        accept_q && is_quad(op_q) |-> cfg_q[`SFCG_CFG_QE_BIT])
        else $error("quad command accepted with quad enable clear");

    a_unready_quiet: assert property (
        !$past(cmd_ready) |-> !accept_q && !exec_q)
        else $error("command taken while not ready");

    a_odd_drop: assert property (
        s_odd_end |=> !exec_q && $stable(cfg_q))
        else $error("odd clock count command executed");

    a_exec_mult: assert property (
        exec_q |-> $past(bits_q[2:0]) == 3'h0 && $past(cs_rise))
        else $error("execution without whole bytes");

    a_pu_delay: assert property (
        s_por_done |=> READY_OUT ##0 !wlatch_q)
        else $error("power-up delay end not honoured");

    a_ready_count: assert property (
        $rose(READY_OUT) |-> $past(por_cnt_q) == PCW'(PU_CYCLES - 1))
        else $error("ready before power-up delay");

    a_por_restart: assert property (
        pwr_q == PWR_FAIL && vcut_s && vmin_s && !hrst_n_s
            |=> pwr_q == PWR_POR && por_cnt_q == '0)
        else $error("reset pin did not restart power-on reset");

    a_lat_quiet: assert property (
        lat_q |-> oe_q == 4'h0)
        else $error("I/O driven during latency");

    a_cnt_clear: assert property (
        cs_fall |=> bits_q == 16'h0000 ##1 bits_q <= 16'h0001)
        else $error("clock counter not cleared at select");

    a_accept_cfg: assert property (
        accept_q |-> dummy_q == dummy_of(op_q,
            cfg_q[`SFCG_CFG_LC_HI:`SFCG_CFG_LC_LO]))
        else $error("dummy count does not follow latency code");

endmodule : sfcg_top

/* pkg/sfcg_regs.svh */
`ifndef SFCG_REGS_SVH
`define SFCG_REGS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SFCG_CLK_PERIOD_NS   25
`define SFCG_PU_TIME_US      300
// Longest time, so the division rounds down
`define SFCG_PU_CYCLES ((`SFCG_PU_TIME_US * 1000) / `SFCG_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Configuration register one
// ----------------------------------------------------------------
`define SFCG_CFG_LC_HI       7
`define SFCG_CFG_LC_LO       6
`define SFCG_CFG_QE_BIT      1
`define SFCG_CFG_RESET       8'h02

// ----------------------------------------------------------------
// Frame bit counts
// ----------------------------------------------------------------
`define SFCG_OPC_BITS        16'h0008
`define SFCG_WREG_FULL_BITS  16'h0018
`define SFCG_ADDR_SINGLE     16'h0018
`define SFCG_ADDR_QUAD       16'h0006
`define SFCG_ADDR_DDR        16'h0003

// ----------------------------------------------------------------
// Mode cycles per read type, dummy cycles per latency code
// ----------------------------------------------------------------
`define SFCG_MODE_NONE       8'h00
`define SFCG_MODE_QIO        8'h02
`define SFCG_MODE_DDR        8'h01
`define SFCG_DUMMY_LC0       8'h08
`define SFCG_DUMMY_LC1       8'h04
`define SFCG_DUMMY_LC2       8'h05
`define SFCG_DUMMY_LC3       8'h06
`define SFCG_DDR_DUMMY_LC0   8'h06
`define SFCG_DDR_DUMMY_LC1   8'h04
`define SFCG_DDR_DUMMY_LC2   8'h05
`define SFCG_DDR_DUMMY_LC3   8'h07

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define SFCG_OP_READ         8'h03
`define SFCG_OP_FAST_READ    8'h0b
`define SFCG_OP_QUAD_OUT     8'h6b
`define SFCG_OP_QIOR         8'heb
`define SFCG_OP_DDR_QIOR     8'hed
`define SFCG_OP_PP           8'h02
`define SFCG_OP_QUAD_PROG    8'h32
`define SFCG_OP_SE           8'hd8
`define SFCG_OP_P4E          8'h20
`define SFCG_OP_BE           8'h60
`define SFCG_OP_WREG         8'h01
`define SFCG_OP_WREN         8'h06
`define SFCG_OP_SW_RESET     8'hf0

`endif

/* pkg/sfcg_pkg.sv */
package sfcg_pkg;

    // Power sequencing states
    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_POR,
        PWR_FAIL,
        PWR_READY
    } sfcg_pwr_t;

endpackage : sfcg_pkg

/* design/sfcg_sync.sv */
`timescale 1ns/1ps

module sfcg_sync #(
    parameter int                 WIDTH   = 1,
    parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // First stage is read only by the second
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Two flip-flop chain
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule : sfcg_sync

/* bench/sfcg_host_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Host controller on the serial link
// ----------------------------------------
module sfcg_host_model (
    // Clock
    input  wire logic clk_in,
    // Link pins
    output logic      cs_n_out,
    output logic      sck_out,
    output logic      si_out
);
    // Deselected, clock parked low between frames
    initial begin
        cs_n_out = 1'b1;
        sck_out  = 1'b0;
        si_out   = 1'b0;
    end

    // One frame, MSB first from the top of data; SCK period 8 clocks
    task automatic frame(input logic [63:0] data, input int nbits);
        int i;
        @(posedge clk_in);
        cs_n_out <= 1'b0;
        for (i = 63; i > 63 - nbits; i--) begin
            si_out <= (i >= 0) ? data[i] : ~si_out;
            repeat (4) @(posedge clk_in);
            sck_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            sck_out <= 1'b0;
        end
        repeat (4) @(posedge clk_in);
        cs_n_out <= 1'b1;
        si_out   <= ~si_out; // Released line never keeps its last value
        repeat (4) @(posedge clk_in);
    endtask : frame
endmodule : sfcg_host_model

/* bench/test_spi_flash_command_gating.sv */
`timescale 1ns/1ps
`include "sfcg_regs.svh"
`define CHK(g, e) check_val(32'(g), 32'(e))

module test_spi_flash_command_gating;
    import sfcg_pkg::*;
    // Short power-up count keeps the run brief
    localparam int PU = 200;
    logic clk, rst, hw_rst_n, vmin, vcut, cs_n, sck, si;
    logic ready, acc, exec, wlatch, lat, hold_en;
    logic [7:0] opc, cfg, mode, dum, last_op, cfg_m;
    logic [3:0] oe;
    logic [55:0] r;
    logic wlatch_m, rdy_m;
    int err_count, total_checks, acc_cnt, ex_cnt, lat_cnt, cyc;
    int oes_cnt, oeq_cnt;
    int n, t0, lc, k, d, l0, s0, q0;
    integer seed = 32'hb9fb4c2c;
    int dsdr [4] = '{8, 4, 5, 6};
    int dddr [4] = '{6, 4, 5, 7};
    logic [7:0] rop [4] = '{8'h0b, 8'h6b, 8'heb, 8'hed};
    int radr [4] = '{24, 24, 6, 3};
    int rmd [4] = '{0, 0, 2, 1};
    logic [7:0] pop [6] = '{8'h02, 8'h32, 8'hd8, 8'h20, 8'h60, 8'h01};
    int pbits [6] = '{40, 40, 32, 32, 8, 24};

    sfcg_top #(.PU_CYCLES(PU)) u_sfcg_top (
        .CLK_SYS_IN(clk), .RST_IN(rst), .CS_N_IN(cs_n), .SCK_IN(sck),
        .SI_IN(si), .HW_RESET_N_IN(hw_rst_n), .VCC_ABOVE_MIN_IN(vmin),
        .VCC_ABOVE_CUTOFF_IN(vcut), .READY_OUT(ready),
        .CMD_ACCEPT_OUT(acc), .CMD_OPCODE_OUT(opc), .EXEC_OUT(exec),
        .WLATCH_OUT(wlatch), .CFG_OUT(cfg), .MODE_CYCLES_OUT(mode),
        .DUMMY_CYCLES_OUT(dum), .LATENCY_OUT(lat), .IO_OE_OUT(oe),
        .HOLD_WP_EN_OUT(hold_en));

    sfcg_host_model u_sfcg_host_model (
        .clk_in(clk), .cs_n_out(cs_n), .sck_out(sck), .si_out(si));

    // 40 MHz system clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Pulse counters, clash watch and hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (acc === 1'b1) acc_cnt <= acc_cnt + 1;
        if (acc === 1'b1) last_op <= opc;
        if (exec === 1'b1) ex_cnt <= ex_cnt + 1;
        if (lat === 1'b1) lat_cnt <= lat_cnt + 1;
        if (lat === 1'b1) `CHK(oe, 0);
        if (oe === 4'h2) oes_cnt <= oes_cnt + 1;
        if (oe === 4'hf) oeq_cnt <= oeq_cnt + 1;
        if (cyc == 60000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check_val

    task automatic print_verdict();
        if (err_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // One frame against the reference: admission, execution, state
    task automatic send(input logic [7:0] op, input logic [55:0] rest,
                        input int nb);
        int a0, e0;
        logic ea, ee;
        a0 = acc_cnt;
        e0 = ex_cnt;
        l0 = lat_cnt;
        ea = rdy_m && vcut && nb >= 8
             && !(op inside {8'h32, 8'h6b, 8'heb, 8'hed} && !cfg_m[1]);
        ee = ea && wlatch_m && nb % 8 == 0 && op inside {pop};
        u_sfcg_host_model.frame({op, rest}, nb);
        repeat (8) @(posedge clk);
        `CHK(acc_cnt - a0, ea);
        `CHK(ex_cnt - e0, ee);
        if (ea) `CHK(last_op, op);
        if (ea && op == 8'h06) wlatch_m = 1'b1;
        if (ee) wlatch_m = 1'b0;
        if (ee && op == 8'h01 && nb == 24) cfg_m = rest[47:40];
        `CHK(wlatch, wlatch_m);
        `CHK(cfg, cfg_m);
        `CHK(hold_en, !cfg_m[1]);
    endtask : send

    // Frame during the delay is ignored, then ready within its bound;
    // t0 is set by the caller at the edge that starts the delay
    task automatic power_wait();
        send(8'h06, 56'h0, 8);
        while (ready !== 1'b1 && cyc - t0 < PU + 40) @(posedge clk);
        n = cyc - t0;
        `CHK(n >= PU && n <= PU + 12, 1);
        rdy_m = 1'b1;
        wlatch_m = 1'b0;
        `CHK(wlatch, 0);
    endtask : power_wait

    // Main sequence
    initial begin
        rst = 1'b1;
        hw_rst_n = 1'b1;
        vmin = 1'b0;
        vcut = 1'b0;
        cfg_m = `SFCG_CFG_RESET;
        wlatch_m = 1'b0;
        rdy_m = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(cfg, 8'h02);
        send(8'h06, 56'h0, 8);
        vmin <= 1'b1;
        vcut <= 1'b1;
        repeat (30) @(posedge clk);
        vmin <= 1'b0;
        repeat (5) @(posedge clk);
        vmin <= 1'b1;
        repeat (PU + 40) @(posedge clk);
        `CHK(ready, 0);
        t0 = cyc;
        hw_rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        hw_rst_n <= 1'b1;
        power_wait();
        // Every latency code against every read type except plain read
        for (lc = 0; lc < 4; lc++) begin
            r = 56'({$random(seed), $random(seed)});
            send(8'h06, 56'h0, 8);
            send(8'h01, {r[55:48], 2'(lc), 4'h0, 1'b1, r[0], 40'h0}, 24);
            for (k = 0; k < 4; k++) begin
                d = (k == 3) ? dddr[lc] : dsdr[lc];
                s0 = oes_cnt;
                q0 = oeq_cnt;
                send(rop[k], r, 8 + radr[k] + rmd[k] + d + 4);
                `CHK(mode, rmd[k]);
                `CHK(dum, d);
                `CHK(lat_cnt - l0, d * 8);
                `CHK(oes_cnt - s0 > 0, k == 0);
                `CHK(oeq_cnt - q0 > 0, k != 0);
            end
        end
        // Odd clock counts are dropped, whole bytes execute
        for (k = 0; k < 6; k++) begin
            r = 56'({$random(seed), $random(seed)});
            r[41] = 1'b1;
            send(8'h06, 56'h0, 8);
            send(pop[k], r, pbits[k] + 1);
            send(pop[k], r, pbits[k]);
        end
        // Quad commands refused while quad enable is clear
        send(8'h06, 56'h0, 8);
        send(8'h01, 56'h0, 24);
        for (k = 0; k < 4; k++) send(rop[k] | 8'h00, r, 16);
        send(8'h32, r, 16);
        send(8'h06, 56'h0, 8);
        send(8'h01, {8'h00, 8'h02, 40'h0}, 24);
        // Supply below cut-off: commands ignored until power returns
        vcut <= 1'b0;
        rdy_m = 1'b0;
        repeat (10) @(posedge clk);
        send(8'h06, 56'h0, 8);
        t0 = cyc;
        vcut <= 1'b1;
        power_wait();
        // Dip below minimum during the delay; software reset restarts
        vcut <= 1'b0;
        rdy_m = 1'b0;
        repeat (10) @(posedge clk);
        vcut <= 1'b1;
        repeat (30) @(posedge clk);
        vmin <= 1'b0;
        repeat (5) @(posedge clk);
        vmin <= 1'b1;
        repeat (PU + 40) @(posedge clk);
        `CHK(ready, 0);
        t0 = cyc;
        send(8'hf0, 56'h0, 8);
        while (ready !== 1'b1 && cyc - t0 < PU + 120) @(posedge clk);
        `CHK(ready, 1);
        rdy_m = 1'b1;
        send(8'h06, 56'h0, 8);
        print_verdict();
    end
endmodule : test_spi_flash_command_gating
